// *** hdl/vf_pkg.sv ***
package vf_pkg;
  localparam logic [7:0] OFS_PRIMARY_FREQ = 8'h00;
  localparam logic [7:0] OFS_SECOND_FREQ = 8'h04;
  localparam logic [7:0] OFS_THIRD_FREQ = 8'h08;
  localparam logic [7:0] OFS_BASE_VOLT = 8'h0c;
  localparam logic [7:0] OFS_LOAD_PATTERN = 8'h10;
  localparam logic [7:0] OFS_TORQUE_BOOST = 8'h14;
  localparam logic [7:0] OFS_ACCEL_CURVE = 8'h18;
  localparam logic [7:0] OFS_APPLIED_MOTOR = 8'h1c;
  localparam logic [7:0] OFS_CTRL_MODE = 8'h20;
  localparam logic [7:0] OFS_MOTOR_CAP = 8'h24;
  localparam logic [7:0] OFS_MOTOR_POLES = 8'h28;
  localparam logic [7:0] OFS_RATED_VOLT = 8'h2c;
  localparam logic [7:0] OFS_RATED_FREQ = 8'h30;
  localparam logic [7:0] OFS_STAT_FREQ = 8'h40;
  localparam logic [7:0] OFS_STAT_VOLT = 8'h44;
  localparam logic [7:0] OFS_STAT_OUT = 8'h48;
  localparam logic [7:0] OFS_STAT_FLAGS = 8'h4c;
  localparam logic [15:0] CODE_95PCT = 16'h22b8;
  localparam logic [15:0] CODE_OFF = 16'h270f;
  localparam logic [15:0] RST_PRIMARY_FREQ = 16'h0258;
  localparam logic [15:0] RST_TORQUE_BOOST = 16'h0014;
  localparam logic [15:0] RST_RATED_VOLT = 16'h00c8;
  localparam logic [15:0] RST_RATED_FREQ = 16'h0258;
  localparam logic [2:0] PAT_LINEAR = 3'h0;
  localparam logic [2:0] PAT_SQUARE = 3'h1;
  localparam logic [2:0] PAT_LIFT_FWD = 3'h2;
  localparam logic [2:0] PAT_LIFT_REV = 3'h3;
  localparam logic [2:0] PAT_SW_FWD = 3'h4;
  localparam logic [2:0] PAT_SW_REV = 3'h5;
  localparam logic [1:0] MODE_VF = 2'h0;
  localparam logic [1:0] ACCEL_S_CURVE_A = 2'h1;
  localparam logic [3:0] MOTOR_FIVE_POINT = 4'h2;
  localparam int unsigned FRAC = 15;
  localparam logic [15:0] UNITY = 16'h8000;
  localparam logic [31:0] PCT_95 = 32'h0000005f;
  localparam logic [15:0] PCT_DEN = 16'h0064;
  localparam logic [15:0] BOOST_DEN = 16'h03e8;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  typedef enum logic [4:0] {
    S_VB = 5'b00001,
    S_RATIO = 5'b00010,
    S_SHAPE = 5'b00100,
    S_BOOST = 5'b01000,
    S_OUT = 5'b10000
  } state_t;
endpackage

// *** hdl/vf_links.sv ***
`timescale 1ns/100ps
`default_nettype none
interface div_if;
  logic start;
  logic [31:0] numer;
  logic [15:0] denom;
  logic done;
  logic [31:0] quot;
  modport req (output start, output numer, output denom, input done, input quot);
  modport unit (input start, input numer, input denom, output done, output quot);
endinterface

interface sel_if;
  logic [15:0] primary_freq;
  logic [15:0] second_freq;
  logic [15:0] third_freq;
  logic second_sel;
  logic third_sel;
  logic five_point;
  logic [2:0] pattern;
  logic switch_on;
  logic reverse;
  logic [15:0] act_freq;
  logic boost_en;
  logic square;
  modport req (output primary_freq, output second_freq, output third_freq, output second_sel,
    output third_sel, output five_point, output pattern, output switch_on, output reverse,
    input act_freq, input boost_en, input square);
  modport unit (input primary_freq, input second_freq, input third_freq, input second_sel,
    input third_sel, input five_point, input pattern, input switch_on, input reverse,
    output act_freq, output boost_en, output square);
endinterface
`default_nettype wire

// *** hdl/seq_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module seq_divider
  import vf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  div_if.unit d
);
  logic [31:0] rem_q;
  logic [31:0] quot_q;
  logic [31:0] num_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [32:0] trial;

  // Restoring division, one quotient bit per clock
  assign trial = {rem_q, num_q[31]} - {17'h00000, d.denom};
  assign d.done = done_q;
  assign d.quot = quot_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q <= 32'h00000000;
      quot_q <= 32'h00000000;
      num_q <= 32'h00000000;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (d.start && !busy_q) begin
        rem_q <= 32'h00000000;
        num_q <= d.numer;
        cnt_q <= DIV_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        num_q <= {num_q[30:0], 1'b0};
        if (!trial[32]) begin
          rem_q <= trial[31:0];
        end else begin
          rem_q <= {rem_q[30:0], num_q[31]};
        end
        quot_q <= {quot_q[30:0], ~trial[32]};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/vf_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module vf_select
  import vf_pkg::*;
(
  sel_if.unit s
);
  logic use_second;
  logic use_third;
  logic [2:0] eff_pat;

  // Five-point motor and the disable code shut out the alternate sets
  assign use_second = s.second_sel && !s.five_point && (s.second_freq != CODE_OFF);
  assign use_third = s.third_sel && !s.five_point && (s.third_freq != CODE_OFF);
  assign s.act_freq = use_third ? s.third_freq : (use_second ? s.second_freq : s.primary_freq);

  always_comb begin
    eff_pat = s.pattern;
    if (s.pattern == PAT_SW_FWD) begin
      eff_pat = s.switch_on ? PAT_LINEAR : PAT_LIFT_FWD;
    end else if (s.pattern == PAT_SW_REV) begin
      eff_pat = s.switch_on ? PAT_LINEAR : PAT_LIFT_REV;
    end
  end

  assign s.square = (eff_pat == PAT_SQUARE);
  assign s.boost_en = (eff_pat == PAT_LIFT_FWD) ? !s.reverse :
                      (eff_pat == PAT_LIFT_REV) ? s.reverse : 1'b1;
endmodule
`default_nettype wire

// *** hdl/vf_pattern_selector.sv ***
`timescale 1ns/100ps
`default_nettype none
module vf_pattern_selector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic second_set_select,
  input wire logic third_set_select,
  input wire logic load_pattern_switch_input,
  input wire logic switch_input_assigned,
  input wire logic reverse_rotation,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] supply_voltage,
  output logic [15:0] output_voltage,
  output logic [15:0] active_base_freq,
  output logic [15:0] s_curve_knee_freq,
  output logic vector_active,
  output logic update_pulse
);
  import vf_pkg::*;

  logic [15:0] primary_base_freq_q;
  logic [15:0] second_base_freq_q;
  logic [15:0] third_base_freq_q;
  logic [15:0] base_voltage_setting_q;
  logic [2:0] load_pattern_select_q;
  logic [15:0] torque_boost_setting_q;
  logic [1:0] accel_curve_select_q;
  logic [3:0] applied_motor_select_q;
  logic [1:0] ctrl_mode_q;
  logic [15:0] motor_capacity_setting_q;
  logic [15:0] motor_pole_count_q;
  logic [15:0] motor_rated_voltage_q;
  logic [15:0] motor_rated_frequency_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic err_d;
  logic wr_ok_d;
  logic wr_fire;
  state_t state_q;
  logic [15:0] fb_q;
  logic [15:0] vb_q;
  logic [15:0] f_q;
  logic [15:0] ratio_q;
  logic [15:0] lin_v_q;
  logic boost_q;
  logic square_q;
  logic vec_q;
  logic div_pend_q;
  logic [15:0] out_v_q;
  logic [15:0] fb_out_q;
  logic [15:0] knee_q;
  logic vec_out_q;
  logic upd_q;
  logic vec_mode;
  logic [15:0] vb_raw;
  logic [31:0] prod_sq;
  logic [31:0] prod_v;
  logic [31:0] prod_taper;
  logic [16:0] sum_v;
  div_if dv();
  sel_if sl();

  seq_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .d(dv)
  );

  vf_select u_sel (
    .s(sl)
  );

  // Register addresses decoded once, for reads and writes alike
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a <= OFS_RATED_FREQ && a[1:0] == 2'b00) ||
                 a == OFS_STAT_FREQ || a == OFS_STAT_VOLT ||
                 a == OFS_STAT_OUT || a == OFS_STAT_FLAGS;
  endfunction

  // APB read mux
  always_comb begin
    rd_d = 32'h00000000;
    if (paddr == OFS_PRIMARY_FREQ) begin
      rd_d = {16'h0000, primary_base_freq_q};
    end else if (paddr == OFS_SECOND_FREQ) begin
      rd_d = {16'h0000, second_base_freq_q};
    end else if (paddr == OFS_THIRD_FREQ) begin
      rd_d = {16'h0000, third_base_freq_q};
    end else if (paddr == OFS_BASE_VOLT) begin
      rd_d = {16'h0000, base_voltage_setting_q};
    end else if (paddr == OFS_LOAD_PATTERN) begin
      rd_d = {29'h00000000, load_pattern_select_q};
    end else if (paddr == OFS_TORQUE_BOOST) begin
      rd_d = {16'h0000, torque_boost_setting_q};
    end else if (paddr == OFS_ACCEL_CURVE) begin
      rd_d = {30'h00000000, accel_curve_select_q};
    end else if (paddr == OFS_APPLIED_MOTOR) begin
      rd_d = {28'h0000000, applied_motor_select_q};
    end else if (paddr == OFS_CTRL_MODE) begin
      rd_d = {30'h00000000, ctrl_mode_q};
    end else if (paddr == OFS_MOTOR_CAP) begin
      rd_d = {16'h0000, motor_capacity_setting_q};
    end else if (paddr == OFS_MOTOR_POLES) begin
      rd_d = {16'h0000, motor_pole_count_q};
    end else if (paddr == OFS_RATED_VOLT) begin
      rd_d = {16'h0000, motor_rated_voltage_q};
    end else if (paddr == OFS_RATED_FREQ) begin
      rd_d = {16'h0000, motor_rated_frequency_q};
    end else if (paddr == OFS_STAT_FREQ) begin
      rd_d = {s_curve_knee_freq, fb_out_q};
    end else if (paddr == OFS_STAT_VOLT) begin
      rd_d = {16'h0000, vb_q};
    end else if (paddr == OFS_STAT_OUT) begin
      rd_d = {16'h0000, out_v_q};
    end else if (paddr == OFS_STAT_FLAGS) begin
      rd_d = {29'h00000000, square_q, boost_q, vec_out_q};
    end
  end

  // Unmapped address, or a voltage code that the five-point curve cannot take
  always_comb begin
    err_d = !addr_known(paddr);
    if (pwrite && paddr == OFS_BASE_VOLT && applied_motor_select_q == MOTOR_FIVE_POINT &&
        (pwdata[15:0] == CODE_95PCT || pwdata[15:0] == CODE_OFF)) begin
      err_d = 1'b1;
    end
  end

  assign wr_ok_d = !err_d;
  assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;

  // Zero-wait answer: pready is raised from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !wr_ok_d;
      if (psel && !penable && !pwrite) begin
        prdata_q <= err_d ? 32'h00000000 : rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_base_freq_q <= RST_PRIMARY_FREQ;
      second_base_freq_q <= CODE_OFF;
      third_base_freq_q <= CODE_OFF;
      base_voltage_setting_q <= CODE_OFF;
      load_pattern_select_q <= PAT_LINEAR;
      torque_boost_setting_q <= RST_TORQUE_BOOST;
      accel_curve_select_q <= 2'h0;
      applied_motor_select_q <= 4'h0;
      ctrl_mode_q <= MODE_VF;
      motor_capacity_setting_q <= CODE_OFF;
      motor_pole_count_q <= CODE_OFF;
      motor_rated_voltage_q <= RST_RATED_VOLT;
      motor_rated_frequency_q <= RST_RATED_FREQ;
    end else if (wr_fire) begin
      if (paddr == OFS_PRIMARY_FREQ) begin
        primary_base_freq_q <= pwdata[15:0];
      end else if (paddr == OFS_SECOND_FREQ) begin
        second_base_freq_q <= pwdata[15:0];
      end else if (paddr == OFS_THIRD_FREQ) begin
        third_base_freq_q <= pwdata[15:0];
      end else if (paddr == OFS_BASE_VOLT) begin
        base_voltage_setting_q <= pwdata[15:0];
      end else if (paddr == OFS_LOAD_PATTERN) begin
        load_pattern_select_q <= pwdata[2:0];
      end else if (paddr == OFS_TORQUE_BOOST) begin
        torque_boost_setting_q <= pwdata[15:0];
      end else if (paddr == OFS_ACCEL_CURVE) begin
        accel_curve_select_q <= pwdata[1:0];
      end else if (paddr == OFS_APPLIED_MOTOR) begin
        applied_motor_select_q <= pwdata[3:0];
      end else if (paddr == OFS_CTRL_MODE) begin
        ctrl_mode_q <= pwdata[1:0];
      end else if (paddr == OFS_MOTOR_CAP) begin
        motor_capacity_setting_q <= pwdata[15:0];
      end else if (paddr == OFS_MOTOR_POLES) begin
        motor_pole_count_q <= pwdata[15:0];
      end else if (paddr == OFS_RATED_VOLT) begin
        motor_rated_voltage_q <= pwdata[15:0];
      end else if (paddr == OFS_RATED_FREQ) begin
        motor_rated_frequency_q <= pwdata[15:0];
      end
    end
  end

  // Vector control only while motor constants are real values
  assign vec_mode = (ctrl_mode_q != MODE_VF) &&
                    (motor_capacity_setting_q != CODE_OFF) &&
                    (motor_pole_count_q != CODE_OFF);

  assign sl.primary_freq = primary_base_freq_q;
  assign sl.second_freq = second_base_freq_q;
  assign sl.third_freq = third_base_freq_q;
  assign sl.second_sel = second_set_select;
  assign sl.third_sel = third_set_select;
  assign sl.five_point = (applied_motor_select_q == MOTOR_FIVE_POINT);
  assign sl.pattern = load_pattern_select_q;
  // Dedicated switch input overrides the second-set select when assigned
  assign sl.switch_on = switch_input_assigned ? load_pattern_switch_input : second_set_select;
  assign sl.reverse = reverse_rotation;

  assign vb_raw = vec_mode ? motor_rated_voltage_q : base_voltage_setting_q;

  assign prod_sq = ratio_q * ratio_q;
  assign prod_v = vb_q * (square_q ? prod_sq[30:15] : ratio_q);
  assign prod_taper = dv.quot[15:0] * (UNITY - ratio_q);
  assign sum_v = {1'b0, lin_v_q} + {1'b0, prod_taper[30:15]};

  // Divider requests per state; start pulses for one cycle, then stays low until the divider answers
  always_comb begin
    dv.start = 1'b0;
    dv.numer = 32'h00000000;
    dv.denom = 16'h0001;
    case (state_q)
      S_VB: begin
        dv.start = !div_pend_q;
        dv.numer = supply_voltage * PCT_95;
        dv.denom = PCT_DEN;
      end
      S_RATIO: begin
        dv.start = !div_pend_q;
        dv.numer = {1'b0, f_q, 15'h0000};
        dv.denom = fb_q;
      end
      S_BOOST: begin
        dv.start = !div_pend_q;
        dv.numer = vb_q * torque_boost_setting_q;
        dv.denom = BOOST_DEN;
      end
      default: begin
        dv.start = 1'b0;
      end
    endcase
  end

  // Pattern pipeline: base voltage, frequency ratio, shape, boost, output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_VB;
      div_pend_q <= 1'b0;
      fb_q <= 16'h0000;
      vb_q <= 16'h0000;
      f_q <= 16'h0000;
      ratio_q <= 16'h0000;
      lin_v_q <= 16'h0000;
      boost_q <= 1'b0;
      square_q <= 1'b0;
      vec_q <= 1'b0;
    end else begin
      if (dv.start) begin
        div_pend_q <= 1'b1;
      end else if (dv.done) begin
        div_pend_q <= 1'b0;
      end
      case (state_q)
        S_VB: begin
          if (dv.done) begin
            vec_q <= vec_mode;
            f_q <= output_freq;
            fb_q <= vec_mode ? motor_rated_frequency_q : sl.act_freq;
            boost_q <= sl.boost_en && !vec_mode;
            square_q <= sl.square && !vec_mode;
            if (vb_raw == CODE_95PCT && !vec_mode) begin
              vb_q <= dv.quot[15:0];
            end else if (vb_raw == CODE_OFF && !vec_mode) begin
              vb_q <= supply_voltage;
            end else if (vb_raw < supply_voltage) begin
              vb_q <= vb_raw;
            end else begin
              vb_q <= supply_voltage;
            end
            state_q <= S_RATIO;
          end
        end
        S_RATIO: begin
          if (dv.done) begin
            // Knee reached or no knee: full base voltage
            if (fb_q == 16'h0000 || f_q >= fb_q) begin
              ratio_q <= UNITY;
            end else begin
              ratio_q <= dv.quot[15:0];
            end
            state_q <= S_SHAPE;
          end
        end
        S_SHAPE: begin
          lin_v_q <= prod_v[30:15];
          state_q <= S_BOOST;
        end
        S_BOOST: begin
          if (dv.done) begin
            state_q <= S_OUT;
          end
        end
        S_OUT: begin
          state_q <= S_VB;
        end
        default: begin
          state_q <= S_VB;
        end
      endcase
    end
  end

  // Results stand until the next pass completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_v_q <= 16'h0000;
      fb_out_q <= 16'h0000;
      knee_q <= 16'h0000;
      vec_out_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (state_q == S_BOOST && dv.done) begin
        upd_q <= 1'b1;
        fb_out_q <= fb_q;
        vec_out_q <= vec_q;
        knee_q <= (accel_curve_select_q == ACCEL_S_CURVE_A) ? sl.act_freq : fb_q;
        if (!boost_q) begin
          out_v_q <= (lin_v_q > vb_q) ? vb_q : lin_v_q;
        end else if (sum_v > {1'b0, vb_q}) begin
          out_v_q <= vb_q;
        end else begin
          out_v_q <= sum_v[15:0];
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign output_voltage = out_v_q;
  assign active_base_freq = fb_out_q;
  assign s_curve_knee_freq = knee_q;
  assign vector_active = vec_out_q;
  assign update_pulse = upd_q;
endmodule
`default_nettype wire

// *** verif/vf_pattern_selector_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module vf_pattern_selector_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] supply_voltage,
  input wire logic [15:0] output_voltage,
  input wire logic [15:0] active_base_freq,
  input wire logic [15:0] s_curve_knee_freq,
  input wire logic vector_active,
  input wire logic update_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  apb_answer_a: assert property (setup_s |=> access_s)
    else $error("access cycle without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access cycle");
  err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  pass_gap_a: assert property (update_pulse |=> !update_pulse[*8] ##[80:120] update_pulse)
    else $error("pattern pass spacing wrong");
  volt_cap_a: assert property (output_voltage <= supply_voltage)
    else $error("output voltage above supply");
  volt_hold_a: assert property ($changed(output_voltage) |-> update_pulse)
    else $error("voltage moved between passes");
  base_hold_a: assert property ($changed(active_base_freq) |-> update_pulse)
    else $error("knee moved between passes");
  vector_hold_a: assert property ($changed(vector_active) |-> update_pulse)
    else $error("vector flag moved between passes");
  knee_match_a: assert property (!vector_active |-> s_curve_knee_freq == active_base_freq)
    else $error("curve knee differs from base");
endmodule
`default_nettype wire

// *** verif/motor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module motor_model #(
  parameter logic [15:0] STEP = 16'h0032,
  parameter logic [15:0] SUPPLY = 16'h00e6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] freq_cmd,
  input wire logic rev_cmd,
  output logic [15:0] output_freq,
  output logic reverse_rotation,
  output logic [15:0] supply_voltage
);
  assign supply_voltage = SUPPLY;
  // Speed slews by STEP; direction only flips at standstill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_freq <= 16'h0000;
      reverse_rotation <= 1'b0;
    end else begin
      if (output_freq == 16'h0000) begin
        reverse_rotation <= rev_cmd;
      end
      if (output_freq + STEP <= freq_cmd) begin
        output_freq <= output_freq + STEP;
      end else if (output_freq >= freq_cmd + STEP) begin
        output_freq <= output_freq - STEP;
      end else begin
        output_freq <= freq_cmd;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/vf_pattern_selector_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
bind vf_pattern_selector vf_pattern_selector_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .supply_voltage(supply_voltage), .output_voltage(output_voltage),
  .active_base_freq(active_base_freq), .s_curve_knee_freq(s_curve_knee_freq),
  .vector_active(vector_active), .update_pulse(update_pulse));
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module vf_pattern_selector_bench;
  import vf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sec_sel = 1'b0;
  logic thr_sel = 1'b0;
  logic sw_in = 1'b0;
  logic sw_asg = 1'b1;
  logic rev_cmd = 1'b0;
  logic [15:0] freq_cmd = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, reverse_rotation, vector_active, update_pulse, bexp;
  logic [15:0] output_freq, supply_voltage, output_voltage, active_base_freq, s_curve_knee_freq;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h2c, 8'h30};
  logic [15:0] rv [7] = '{16'h0258, 16'h270f, 16'h270f, 16'h270f, 16'h0014, 16'h00c8, 16'h0258};
  logic [15:0] bv [4] = '{16'h270f, 16'h22b8, 16'h00b4, 16'h012c};
  logic [15:0] ev [4] = '{16'h00e6, 16'h00da, 16'h00b4, 16'h00e6};
  logic [15:0] fe [4] = '{16'h0258, 16'h01f4, 16'h0190, 16'h0190};
  int err_total = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  vf_pattern_selector DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .second_set_select(sec_sel), .third_set_select(thr_sel),
    .load_pattern_switch_input(sw_in), .switch_input_assigned(sw_asg),
    .reverse_rotation(reverse_rotation), .output_freq(output_freq),
    .supply_voltage(supply_voltage), .output_voltage(output_voltage),
    .active_base_freq(active_base_freq), .s_curve_knee_freq(s_curve_knee_freq),
    .vector_active(vector_active), .update_pulse(update_pulse));
  motor_model MOTOR (.pclk(pclk), .presetn(presetn), .freq_cmd(freq_cmd), .rev_cmd(rev_cmd),
    .output_freq(output_freq), .reverse_rotation(reverse_rotation),
    .supply_voltage(supply_voltage));
  task test_done;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    `CHK(er, e)
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, x)
    `CHK(er, e)
  endtask
  // Three passes so the sampled inputs are surely the new ones
  task settle(input logic [15:0] f, input logic r);
    int n;
    n = 0;
    freq_cmd <= f;
    rev_cmd <= r;
    repeat (3) begin
      do begin
        @(posedge pclk);
        n++;
      end while (update_pulse !== 1'b1 && n < 1000);
    end
    if (n >= 1000) begin
      err_total++;
      test_done;
    end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(ra[i], {16'h0, rv[i]}, 1'b0);
    rdc(8'h3c, 32'h0, 1'b1);
    wr(OFS_TORQUE_BOOST, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BASE_VOLT, {16'h0, bv[i]}, 1'b0);
      settle(16'h0384, 1'b0);
      `CHK(output_voltage, ev[i])
    end
    wr(OFS_BASE_VOLT, 32'h00c8, 1'b0);
    settle(16'h012c, 1'b0);
    `CHK(output_voltage, 16'h0064)
    settle(16'h0258, 1'b0);
    `CHK(output_voltage, 16'h00c8)
    wr(OFS_LOAD_PATTERN, 32'h1, 1'b0);
    settle(16'h012c, 1'b0);
    `CHK(output_voltage, 16'h0032)
    wr(OFS_TORQUE_BOOST, 32'h0014, 1'b0);
    for (int p = 0; p < 6; p++) begin
      wr(OFS_LOAD_PATTERN, 32'(p), 1'b0);
      for (int s = 0; s < 2; s++) begin
        for (int r = 0; r < 2; r++) begin
          sw_in <= s[0];
          bexp = p < 2 || (p > 3 && s == 1) || ((p == 2 || p == 4) && r == 0)
            || ((p == 3 || p == 5) && r == 1);
          settle(16'h0000, r[0]);
          `CHK(output_voltage, bexp ? 16'h0004 : 16'h0000)
        end
      end
    end
    wr(OFS_LOAD_PATTERN, 32'h4, 1'b0);
    sw_asg <= 1'b0;
    sec_sel <= 1'b1;
    settle(16'h0000, 1'b1);
    `CHK(output_voltage, 16'h0004)
    wr(OFS_SECOND_FREQ, 32'h01f4, 1'b0);
    wr(OFS_THIRD_FREQ, 32'h0190, 1'b0);
    for (int i = 0; i < 4; i++) begin
      sec_sel <= i[0];
      thr_sel <= i[1];
      settle(16'h0384, 1'b0);
      `CHK(active_base_freq, fe[i])
    end
    wr(OFS_APPLIED_MOTOR, 32'h2, 1'b0);
    settle(16'h0384, 1'b0);
    `CHK(active_base_freq, 16'h0258)
    wr(OFS_BASE_VOLT, 32'h22b8, 1'b1);
    wr(OFS_BASE_VOLT, 32'h270f, 1'b1);
    rdc(OFS_BASE_VOLT, 32'h00c8, 1'b0);
    wr(OFS_APPLIED_MOTOR, 32'h0, 1'b0);
    wr(OFS_THIRD_FREQ, 32'h270f, 1'b0);
    wr(OFS_SECOND_FREQ, 32'h270f, 1'b0);
    settle(16'h0384, 1'b0);
    `CHK(active_base_freq, 16'h0258)
    sec_sel <= 1'b0;
    thr_sel <= 1'b0;
    wr(OFS_CTRL_MODE, 32'h1, 1'b0);
    wr(OFS_RATED_VOLT, 32'h00be, 1'b0);
    wr(OFS_RATED_FREQ, 32'h01f4, 1'b0);
    settle(16'h0384, 1'b0);
    `CHK(vector_active, 1'b0)
    wr(OFS_MOTOR_CAP, 32'h000a, 1'b0);
    wr(OFS_MOTOR_POLES, 32'h0004, 1'b0);
    wr(OFS_ACCEL_CURVE, 32'h1, 1'b0);
    settle(16'h0384, 1'b0);
    `CHK(vector_active, 1'b1)
    `CHK(active_base_freq, 16'h01f4)
    `CHK(output_voltage, 16'h00be)
    `CHK(s_curve_knee_freq, 16'h0258)
    rdc(OFS_STAT_FREQ, {16'h0258, 16'h01f4}, 1'b0);
    rdc(OFS_STAT_VOLT, 32'h00be, 1'b0);
    // Status words are read-only: the write is dropped without error
    wr(OFS_STAT_OUT, 32'h0, 1'b0);
    rdc(OFS_STAT_OUT, 32'h00be, 1'b0);
    rdc(OFS_STAT_FLAGS, 32'h1, 1'b0);
    test_done;
  end
  initial begin
    #400000;
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
